//--- src/acdma_top.sv
// Chosen here: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
module acdma_top (
  // clock and reset
  input  wire logic                   CLOCK,
  input  wire logic                   RSTN,
  // register bus slave
  input  wire logic [4:0]             AVS_ADDRESS,
  input  wire logic                   AVS_READ,
  input  wire logic                   AVS_WRITE,
  input  wire logic [31:0]            AVS_WRITEDATA,
  output logic [31:0]                 AVS_READDATA,
  output logic                        AVS_WAITREQUEST,
  // converter side
  input  wire acdma_pkg::acdma_conv_t CONV_RESULT,
  output logic                        CONV_ENABLE,
  // RAM write master
  output logic [31:0]                 DMA_ADDRESS,
  output logic                        DMA_WRITE,
  output logic [15:0]                 DMA_WRITEDATA,
  input  wire logic                   DMA_WAITREQUEST
);
  import acdma_pkg::*;

  typedef struct packed {
    acdma_state_t st;
    logic [15:0]  cfg;
    logic [15:0]  offset;
    logic [15:0]  gain;
    logic [31:0]  start;
    logic [15:0]  size;
    logic [15:0]  count;
    logic [31:0]  nextaddr;
    logic         wrap;
    logic [3:0]   status;
    logic         drop;
    logic         pend;
    logic [15:0]  pend_data;
    logic         dma_wr;
    logic         av_wait;
    logic [31:0]  rdata;
  } acdma_top_s_t;

  acdma_top_s_t s_q;
  acdma_top_s_t s_d;
  acdma_conv_t  corr_in;
  acdma_corr_t  corr_out;
  logic         conv_ok;
  logic         dma_acc;
  logic         wr_done;
  logic         ctl_wr;
  logic [15:0]  cnt_inc;
  logic [15:0]  half_mark;
  logic [3:0]   st_set;
  logic [3:0]   st_clr;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  assign dma_acc   = s_q.dma_wr && !DMA_WAITREQUEST;
  assign wr_done   = !s_q.av_wait && AVS_WRITE;
  assign ctl_wr    = wr_done && AVS_ADDRESS == ACDMA_OFS_CTRL;
  assign cnt_inc   = s_q.count + 16'h0001;
  assign half_mark = {1'b0, s_q.size[15:1]};

  acdma_correct u_correct (
    .clk     (CLOCK),
    .rstn    (RSTN),
    .raw_in  (corr_in),
    .offset  (s_q.offset),
    .gain    (s_q.gain),
    .res_out (corr_out)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d    = s_q;
    st_set = 4'h0;
    st_clr = 4'h0;

    // results arrive only while enabled; the modulator is free running then
    conv_ok       = CONV_RESULT.valid && s_q.cfg[ACDMA_CFG_EN];
    corr_in.valid = conv_ok && !s_q.drop;
    corr_in.data  = CONV_RESULT.data;
    if (conv_ok) begin
      s_d.drop = 1'b0;
    end

    // corrected sample to the single holding slot
    if (corr_out.valid) begin
      st_set[ACDMA_ST_CLIP] = corr_out.clip;
      if (s_q.st == ACDMA_RUN && !s_q.pend) begin
        s_d.pend      = 1'b1;
        s_d.pend_data = corr_out.data;
      end else if (s_q.st != ACDMA_IDLE) begin
        // no room: a stopped buffer (linear and full, or loaded empty) or a slot still in flight
        st_set[ACDMA_ST_OVR] = 1'b1;
      end
    end

    // halfword write to RAM
    if (s_q.pend && !s_q.dma_wr && s_q.st == ACDMA_RUN) begin
      s_d.dma_wr = 1'b1;
    end
    if (dma_acc) begin
      s_d.dma_wr = 1'b0;
      s_d.pend   = 1'b0;
      if (s_q.st == ACDMA_RUN) begin
        s_d.nextaddr = s_q.nextaddr + ACDMA_ADDR_STEP;
        s_d.count    = cnt_inc;
        if (cnt_inc == half_mark) begin
          st_set[ACDMA_ST_HALF] = 1'b1;
        end
        if (cnt_inc == s_q.size) begin
          st_set[ACDMA_ST_FULL] = 1'b1;
          if (s_q.wrap) begin
            s_d.nextaddr = s_q.start;
            s_d.count    = 16'h0000;
          end else begin
            s_d.st = ACDMA_STOPPED;
          end
        end
      end
    end

    // register bus: waitrequest drops one cycle after the request appears
    if (s_q.av_wait) begin
      if (AVS_READ || AVS_WRITE) begin
        s_d.av_wait = 1'b0;
        case (AVS_ADDRESS)
          ACDMA_OFS_CONFIG: s_d.rdata = {16'h0000, s_q.cfg};
          ACDMA_OFS_OFFSET: s_d.rdata = {16'h0000, s_q.offset};
          ACDMA_OFS_GAIN:   s_d.rdata = {16'h0000, s_q.gain};
          ACDMA_OFS_STATUS: s_d.rdata = {28'h0000000, s_q.status};
          ACDMA_OFS_START:  s_d.rdata = s_q.start;
          ACDMA_OFS_COUNT:  s_d.rdata = {16'h0000, s_q.size};
          ACDMA_OFS_CTRL:   s_d.rdata = {28'h0000000, s_q.st == ACDMA_RUN, s_q.wrap, 2'b00};
          ACDMA_OFS_NEXT:   s_d.rdata = s_q.nextaddr;
          default:          s_d.rdata = 32'h00000000;
        endcase
      end
    end else begin
      s_d.av_wait = 1'b1;
      if (AVS_WRITE) begin
        case (AVS_ADDRESS)
          ACDMA_OFS_CONFIG: begin
            s_d.cfg  = AVS_WRITEDATA[15:0];
            s_d.drop = 1'b1;
          end
          ACDMA_OFS_OFFSET: s_d.offset = AVS_WRITEDATA[15:0];
          ACDMA_OFS_GAIN:   s_d.gain   = AVS_WRITEDATA[15:0];
          ACDMA_OFS_STATUS: st_clr     = AVS_WRITEDATA[3:0];
          ACDMA_OFS_START:  s_d.start  = {AVS_WRITEDATA[31:1], 1'b0};
          ACDMA_OFS_COUNT:  s_d.size   = AVS_WRITEDATA[15:0];
          ACDMA_OFS_CTRL: begin
            s_d.wrap = AVS_WRITEDATA[ACDMA_CTL_WRAP];
            if (AVS_WRITEDATA[ACDMA_CTL_RESET]) begin
              s_d.st       = ACDMA_IDLE;
              s_d.count    = 16'h0000;
              s_d.pend     = 1'b0;
              s_d.nextaddr = s_q.start;
            end
            if (AVS_WRITEDATA[ACDMA_CTL_LOAD]) begin
              // an empty buffer has nowhere to write, so it reads as stopped
              s_d.st       = (s_q.size == 16'h0000) ? ACDMA_STOPPED : ACDMA_RUN;
              s_d.count    = 16'h0000;
              s_d.pend     = 1'b0;
              s_d.nextaddr = s_q.start;
            end
          end
          default: ;
        endcase
      end
    end

    // a flag raised in the cycle it is cleared survives
    s_d.status = (s_q.status & ~st_clr) | st_set;
  end

  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      s_q         <= '0;
      s_q.offset  <= ACDMA_OFFSET_RST;
      s_q.gain    <= ACDMA_GAIN_RST;
      s_q.av_wait <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign AVS_READDATA    = s_q.rdata;
  assign AVS_WAITREQUEST = s_q.av_wait;
  assign CONV_ENABLE     = s_q.cfg[ACDMA_CFG_EN];
  assign DMA_ADDRESS     = s_q.nextaddr;
  assign DMA_WRITE       = s_q.dma_wr;
  assign DMA_WRITEDATA   = s_q.pend_data;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RSTN);

  reset_values_a: assert property ($rose(RSTN) |->
    s_q.gain == 16'h8000 && s_q.offset == 16'h0000)
    else $error("offset or gain wrong after reset");
  first_drop_a: assert property (s_q.drop && conv_ok |-> !corr_in.valid ##1 !s_q.drop)
    else $error("first result after change not dropped");
  disabled_quiet_a: assert property (!CONV_ENABLE |-> !corr_in.valid ##1 !corr_out.valid)
    else $error("result taken while converter disabled");
  idle_no_write_a: assert property (s_q.st == ACDMA_IDLE && !DMA_WRITE |=> !DMA_WRITE)
    else $error("write started before load");
  addr_step_a: assert property (dma_acc && s_q.st == ACDMA_RUN && cnt_inc != s_q.size && !ctl_wr
    |=> DMA_ADDRESS == $past(DMA_ADDRESS) + 32'h00000002)
    else $error("write address did not advance by two");
  wrap_return_a: assert property (dma_acc && s_q.st == ACDMA_RUN && s_q.wrap
    && cnt_inc == s_q.size && !ctl_wr |=> DMA_ADDRESS == s_q.start && s_q.st == ACDMA_RUN)
    else $error("wrap did not return to buffer start");
  linear_stop_a: assert property (dma_acc && s_q.st == ACDMA_RUN && !s_q.wrap
    && cnt_inc == s_q.size && !ctl_wr |=> s_q.st == ACDMA_STOPPED && s_q.status[ACDMA_ST_FULL]
    ##1 !DMA_WRITE)
    else $error("linear buffer did not stop full");
  overrun_set_a: assert property (s_q.st == ACDMA_STOPPED && corr_out.valid && !ctl_wr
    |=> s_q.status[ACDMA_ST_OVR])
    else $error("overrun not flagged");
  half_flag_a: assert property (dma_acc && s_q.st == ACDMA_RUN && cnt_inc == half_mark
    |=> s_q.status[ACDMA_ST_HALF])
    else $error("half flag not set");
  clip_flag_a: assert property (corr_out.valid && corr_out.clip |=> s_q.status[ACDMA_ST_CLIP])
    else $error("clip flag not set");

  wrap_seen_c:    cover property (dma_acc && s_q.wrap && cnt_inc == s_q.size);
  linear_full_c:  cover property (s_q.st == ACDMA_STOPPED && s_q.status[ACDMA_ST_FULL]);
  overrun_seen_c: cover property (s_q.status[ACDMA_ST_OVR]);
endmodule

//--- include/acdma_pkg.sv
package acdma_pkg;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [4:0] ACDMA_OFS_CONFIG = 5'h00;
  localparam logic [4:0] ACDMA_OFS_OFFSET = 5'h04;
  localparam logic [4:0] ACDMA_OFS_GAIN   = 5'h08;
  localparam logic [4:0] ACDMA_OFS_STATUS = 5'h0C;
  localparam logic [4:0] ACDMA_OFS_START  = 5'h10;
  localparam logic [4:0] ACDMA_OFS_COUNT  = 5'h14;
  localparam logic [4:0] ACDMA_OFS_CTRL   = 5'h18;
  localparam logic [4:0] ACDMA_OFS_NEXT   = 5'h1C;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int ACDMA_CFG_EN    = 0;
  localparam int ACDMA_CTL_LOAD  = 0;
  localparam int ACDMA_CTL_RESET = 1;
  localparam int ACDMA_CTL_WRAP  = 2;
  localparam int ACDMA_CTL_RUN   = 3;
  localparam int ACDMA_ST_CLIP   = 0;
  localparam int ACDMA_ST_HALF   = 1;
  localparam int ACDMA_ST_FULL   = 2;
  localparam int ACDMA_ST_OVR    = 3;

  // ----------------------------------------------------------------
  // reset values and limits
  // ----------------------------------------------------------------
  localparam logic [15:0]        ACDMA_OFFSET_RST = 16'h0000;
  localparam logic [15:0]        ACDMA_GAIN_RST   = 16'h8000;
  localparam logic signed [18:0] ACDMA_SAT_HI     = 19'sh07FFF;
  localparam logic signed [18:0] ACDMA_SAT_LO     = 19'sh78000;
  localparam logic [15:0]        ACDMA_CLIP_HI    = 16'h7FFF;
  localparam logic [15:0]        ACDMA_CLIP_LO    = 16'h8000;
  localparam logic [31:0]        ACDMA_ADDR_STEP  = 32'h00000002;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ACDMA_IDLE, ACDMA_RUN, ACDMA_STOPPED} acdma_state_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] data;
  } acdma_conv_t;

  typedef struct packed {
    logic        valid;
    logic        clip;
    logic [15:0] data;
  } acdma_corr_t;

endpackage

//--- src/acdma_correct.sv
`timescale 1ns/100ps
module acdma_correct (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rstn,
  // raw result and settings
  input  wire acdma_pkg::acdma_conv_t raw_in,
  input  wire logic [15:0]            offset,
  input  wire logic [15:0]            gain,
  // corrected result
  output acdma_pkg::acdma_corr_t      res_out
);
  import acdma_pkg::*;

  typedef struct packed {
    acdma_corr_t res;
  } acdma_cor_s_t;

  acdma_cor_s_t      s_q;
  acdma_cor_s_t      s_d;
  logic signed [16:0] sum;
  logic signed [33:0] prod;
  logic signed [18:0] scaled;
  logic [15:0]        clip_flag;

  always_comb begin
    s_d = s_q;
    sum = $signed({raw_in.data[15], raw_in.data}) + $signed({offset[15], offset});
    prod = sum * $signed({1'b0, gain});
    scaled = prod[33:15];
    s_d.res.clip = 1'b0;
    if (scaled > ACDMA_SAT_HI) begin
      clip_flag = ACDMA_CLIP_HI;
      s_d.res.clip = 1'b1;
    end else if (scaled < ACDMA_SAT_LO) begin
      clip_flag = ACDMA_CLIP_LO;
      s_d.res.clip = 1'b1;
    end else begin
      clip_flag = scaled[15:0];
    end
    s_d.res.data  = {clip_flag[15], clip_flag[15:1]};
    s_d.res.valid = raw_in.valid;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign res_out = s_q.res;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  clip_bound_a: assert property (res_out.valid && res_out.clip |->
    (res_out.data == 16'h3FFF || res_out.data == 16'hC000))
    else $error("clipped result not at halved limit");
  halve_sign_a: assert property (res_out.valid |-> res_out.data[15] == res_out.data[14])
    else $error("result not halved");
  unity_gain_a: assert property (raw_in.valid && gain == 16'h8000 && offset == 16'h0000
    |=> res_out.valid && res_out.data == {$past(raw_in.data[15]), $past(raw_in.data[15:1])})
    else $error("unity gain changed the value");
  zero_gain_a: assert property (raw_in.valid && gain == 16'h0000
    |=> res_out.data == 16'h0000 && !res_out.clip)
    else $error("zero gain gave nonzero result");
  offset_add_a: assert property (raw_in.valid && raw_in.data == 16'h0000 && gain == 16'h8000
    |=> res_out.data == {$past(offset[15]), $past(offset[15:1])})
    else $error("offset not added");
  clip_seen_c: cover property (res_out.valid && res_out.clip);
endmodule

//--- verification/acdma_ram_model.sv
`timescale 1ns/100ps
module acdma_ram_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // stall control from the bench
  input  wire logic        slow,
  // halfword write slave
  input  wire logic [31:0] address,
  input  wire logic        write,
  input  wire logic [15:0] writedata,
  output logic             waitrequest
);
  logic [15:0] mem [0:255];
  logic [1:0]  wait_q;
  int          wr_count;

  // slow mode holds each write off for two cycles, so a master that drops early is caught
  assign waitrequest = !(write && (!slow || wait_q == 2'h2));

  always_ff @(posedge clk) begin
    if (!rstn) begin
      wait_q   <= 2'h0;
      wr_count <= 0;
    end else if (write && !waitrequest) begin
      mem[address[8:1]] <= writedata;
      wait_q            <= 2'h0;
      wr_count          <= wr_count + 1;
    end else if (write) begin
      wait_q <= wait_q + 2'h1;
    end
  end
endmodule

//--- verification/acdma_top_test.sv
`timescale 1ns/100ps
module acdma_top_test;
  import acdma_pkg::*;
  logic        CLOCK, RSTN, AVS_READ, AVS_WRITE, CONV_ENABLE, DMA_WRITE, DMA_WAITREQUEST;
  logic [4:0]  AVS_ADDRESS;
  logic [31:0] AVS_WRITEDATA, AVS_READDATA, DMA_ADDRESS, q;
  logic        AVS_WAITREQUEST, slow;
  logic [15:0] DMA_WRITEDATA;
  acdma_conv_t CONV_RESULT;
  logic [15:0] exp_q [$];
  int          mismatches, checked, cycles;

  acdma_top u_dut (.CLOCK(CLOCK), .RSTN(RSTN), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .CONV_RESULT(CONV_RESULT), .CONV_ENABLE(CONV_ENABLE),
    .DMA_ADDRESS(DMA_ADDRESS), .DMA_WRITE(DMA_WRITE), .DMA_WRITEDATA(DMA_WRITEDATA),
    .DMA_WAITREQUEST(DMA_WAITREQUEST));
  acdma_ram_model u_ram (.clk(CLOCK), .rstn(RSTN), .slow(slow), .address(DMA_ADDRESS),
    .write(DMA_WRITE), .writedata(DMA_WRITEDATA), .waitrequest(DMA_WAITREQUEST));

  initial begin
    CLOCK = 1'b0;
    forever #5 CLOCK = ~CLOCK;
  end

  // --------------------------------------------------------------
  // shared tasks
  // --------------------------------------------------------------
  task end_of_test();
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: seen 0x%08X expected 0x%08X", $time, seen, exp);
    end
  endtask

  // one request, held until waitrequest is sampled low at an edge
  task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    @(posedge CLOCK);
    AVS_ADDRESS   <= a;
    AVS_WRITE     <= wr;
    AVS_READ      <= !wr;
    AVS_WRITEDATA <= d;
    n = 0;
    do begin
      @(posedge CLOCK);
      n++;
    end while (AVS_WAITREQUEST !== 1'b0 && n < 50);
    if (n >= 50) mismatches++;
    q = AVS_READDATA;
    AVS_READ  <= 1'b0;
    AVS_WRITE <= 1'b0;
  endtask

  task rd_check(input logic [4:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h00000000);
    check(q, exp);
  endtask

  // spacing leaves room for the slow RAM plus the three-stage pipeline
  task conv(input logic [15:0] d);
    @(posedge CLOCK);
    CONV_RESULT <= '{valid: 1'b1, data: d};
    @(posedge CLOCK);
    CONV_RESULT.valid <= 1'b0;
    repeat (14) @(posedge CLOCK);
  endtask

  function automatic logic [15:0] corr(input logic [15:0] raw, off, gain);
    logic signed [16:0] s;
    logic signed [34:0] p;
    logic signed [15:0] r;
    s = $signed({raw[15], raw}) + $signed({off[15], off});
    p = (s * $signed({1'b0, gain})) >>> 15;
    if (p > 35'sd32767) r = 16'sh7FFF;
    else if (p < -35'sd32768) r = 16'sh8000;
    else r = p[15:0];
    return r >>> 1;
  endfunction

  task samp(input logic [15:0] raw, off, gain);
    bus(1'b1, ACDMA_OFS_OFFSET, {16'h0000, off});
    bus(1'b1, ACDMA_OFS_GAIN, {16'h0000, gain});
    exp_q.push_back(corr(raw, off, gain));
    conv(raw);
  endtask

  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  task t_reset_values();
    rd_check(ACDMA_OFS_OFFSET, 32'h00000000);
    rd_check(ACDMA_OFS_GAIN, 32'h00008000);
    rd_check(ACDMA_OFS_STATUS, 32'h00000000);
    rd_check(ACDMA_OFS_NEXT, 32'h00000000);
    rd_check(5'h02, 32'h00000000);
    check(CONV_ENABLE, 1'b0);
  endtask

  task t_linear();
    bus(1'b1, ACDMA_OFS_CTRL, 32'h00000002);
    bus(1'b1, ACDMA_OFS_START, 32'h00000040);
    bus(1'b1, ACDMA_OFS_COUNT, 32'h00000004);
    bus(1'b1, ACDMA_OFS_CTRL, 32'h00000001);
    bus(1'b1, ACDMA_OFS_CONFIG, 32'h00000001);
    // the write lands at this edge; look once the register has settled
    @(negedge CLOCK);
    check(CONV_ENABLE, 1'b1);
    conv(16'h5555);
    check(u_ram.wr_count, 0);
    samp(16'h1230, 16'h0000, 16'h8000);
    samp(16'h7000, 16'h1000, 16'hFFFF);
    rd_check(ACDMA_OFS_STATUS, 32'h00000003);
    samp(16'h8000, 16'hF000, 16'h4000);
    samp(16'h0100, 16'h0000, 16'h0000);
    for (int i = 0; i < 4; i++) check(u_ram.mem[32 + i], exp_q[i]);
    rd_check(ACDMA_OFS_NEXT, 32'h00000048);
    rd_check(ACDMA_OFS_STATUS, 32'h00000007);
    conv(16'h1111);
    check(u_ram.wr_count, 4);
    rd_check(ACDMA_OFS_STATUS, 32'h0000000F);
    bus(1'b0, ACDMA_OFS_CTRL, 32'h00000000);
    check(q[3], 1'b0);
  endtask

  task t_wrap();
    slow <= 1'b1;
    bus(1'b1, ACDMA_OFS_STATUS, 32'h0000000F);
    rd_check(ACDMA_OFS_STATUS, 32'h00000000);
    bus(1'b1, ACDMA_OFS_CTRL, 32'h00000002);
    bus(1'b1, ACDMA_OFS_START, 32'h00000080);
    bus(1'b1, ACDMA_OFS_COUNT, 32'h00000003);
    bus(1'b1, ACDMA_OFS_CTRL, 32'h00000005);
    bus(1'b1, ACDMA_OFS_CONFIG, 32'h00000001);
    conv(16'h4321);
    check(u_ram.wr_count, 4);
    exp_q.delete();
    for (int i = 1; i <= 4; i++) samp(16'(i * 16'h0200), 16'h0000, 16'h8000);
    check(u_ram.mem[64], exp_q[3]);
    check(u_ram.mem[65], exp_q[1]);
    check(u_ram.mem[66], exp_q[2]);
    rd_check(ACDMA_OFS_NEXT, 32'h00000082);
    rd_check(ACDMA_OFS_STATUS, 32'h00000006);
    rd_check(ACDMA_OFS_CTRL, 32'h0000000C);
    bus(1'b1, ACDMA_OFS_CTRL, 32'h00000002);
    bus(1'b0, ACDMA_OFS_CTRL, 32'h00000000);
    check(q[3], 1'b0);
    bus(1'b1, ACDMA_OFS_CONFIG, 32'h00000000);
    @(negedge CLOCK);
    check(CONV_ENABLE, 1'b0);
    conv(16'h2222);
    check(u_ram.wr_count, 8);
  endtask

  // --------------------------------------------------------------
  // main sequence and timeout
  // --------------------------------------------------------------
  initial begin
    RSTN = 1'b0;
    AVS_ADDRESS = 5'h00;
    AVS_READ = 1'b0;
    AVS_WRITE = 1'b0;
    AVS_WRITEDATA = 32'h00000000;
    CONV_RESULT = '{valid: 1'b0, data: 16'h0000};
    slow = 1'b0;
    mismatches = 0;
    checked = 0;
    repeat (4) @(posedge CLOCK);
    RSTN <= 1'b1;
    t_reset_values();
    t_linear();
    t_wrap();
    end_of_test();
  end

  initial begin
    cycles = 0;
    while (cycles < 5000) begin
      @(posedge CLOCK);
      cycles++;
    end
    mismatches++;
    end_of_test();
  end
endmodule
